// ### rtl/bgd_gate_ctrl.sv
// Purpose: Control logic of a three-phase brushless gate controller.
// Assumes: Logic inputs and analog monitor results arrive as levels.
// Notes:   Disable acts as a synchronous clear of the fault logic.
`timescale 1ns/10ps
module bgd_gate_ctrl #(
  parameter int BootTimeoutCyc = bgd_pkg::BOOT_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst,
  // Logic inputs from the host
  input  wire logic [2:0]                 hallInputs,
  input  wire logic                       dirIn,
  input  wire logic                       brakeIn,
  input  wire logic                       decaySel,
  input  wire logic                       speedChop,
  input  wire logic                       disableIn,
  input  wire logic                       powerLossBrakeSelect,
  // Analog monitor results
  input  wire logic                       senseTrip,
  input  wire logic [2:0]                 gateSrcLow,
  input  wire logic [2:0]                 bootCharged,
  input  wire logic                       gateSupplyOk,
  // Gate drive and fault outputs
  output logic [2:0]                      sourceGateOutputs,
  output logic [2:0]                      sinkGateOutputs,
  output logic                            faultOut,
  // Register port
  input  wire logic [bgd_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [bgd_pkg::DATA_W-1:0] regWrData,
  input  wire logic                       regWrEn,
  input  wire logic                       regRdEn,
  output logic [bgd_pkg::DATA_W-1:0]      regRdData
);
  import bgd_pkg::*;

  localparam logic [TMR_W-1:0] BOOT_LAST = TMR_W'(BootTimeoutCyc - 1);
  localparam logic [TMR_W-1:0] MIN_OFF   = TMR_W'(MIN_OFF_CYC);

  // ==========================================================
  // Input synchroniser
  logic [SYNC_W-1:0] syncA_r;
  logic [SYNC_W-1:0] syncB_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= {gateSupplyOk, bootCharged, gateSrcLow, senseTrip,
                  powerLossBrakeSelect, disableIn, speedChop, decaySel,
                  brakeIn, dirIn, hallInputs};
      syncB_r <= syncA_r;
    end
  end

  logic [2:0] hall;
  logic [2:0] gsLow;
  logic [2:0] bootOk;
  logic       dis;
  logic       chop;
  logic       uv;
  assign hall   = syncB_r[SY_HALL +: 3];
  assign gsLow  = syncB_r[SY_GS +: 3];
  assign bootOk = syncB_r[SY_BOK +: 3];
  assign dis    = syncB_r[SY_DIS];
  assign chop   = syncB_r[SY_CHOP];
  assign uv     = !syncB_r[SY_SUP];

  // ==========================================================
  // Commutation decode
  function automatic logic [5:0] decodeHall(input logic [2:0] h, input logic fwd);
    logic [5:0] p;
    logic [5:0] q;
    p = {DRV_Z, DRV_Z, DRV_Z};
    case (h)
      3'h5:    p = {DRV_LO, DRV_Z, DRV_HI};
      3'h4:    p = {DRV_LO, DRV_HI, DRV_Z};
      3'h6:    p = {DRV_Z, DRV_HI, DRV_LO};
      3'h2:    p = {DRV_HI, DRV_Z, DRV_LO};
      3'h3:    p = {DRV_HI, DRV_LO, DRV_Z};
      3'h1:    p = {DRV_Z, DRV_LO, DRV_HI};
      default: p = {DRV_Z, DRV_Z, DRV_Z};
    endcase
    q = p;
    // Reverse rotation swaps source and sink of each driven phase.
    for (int i = 0; i < 3; i++) begin
      if (!fwd && p[2*i +: 2] == DRV_HI) begin
        q[2*i +: 2] = DRV_LO;
      end else if (!fwd && p[2*i +: 2] == DRV_LO) begin
        q[2*i +: 2] = DRV_HI;
      end
    end
    return q;
  endfunction

  logic [5:0] pat;
  logic [5:0] patPrev_r;
  logic [2:0] hallPrev_r;
  logic       hallBad;
  logic       commStart;

  assign pat       = decodeHall(hall, syncB_r[SY_DIR]);
  assign hallBad   = (hall == HALL_ALL_LO) || (hall == HALL_ALL_HI);
  assign commStart = !hallBad && (hall != hallPrev_r);

  // Previous hall code and pattern for step and Z-to-source detection.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hallPrev_r <= HALL_ALL_LO;
      patPrev_r  <= {DRV_Z, DRV_Z, DRV_Z};
    end else begin
      hallPrev_r <= hall;
      patPrev_r  <= pat;
    end
  end

  // ==========================================================
  // Registers
  logic [7:0]  deadTime_r;
  logic [15:0] offTime_r;
  logic [15:0] blankTime_r;

  // Software-written timing registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      deadTime_r  <= DEAD_RST;
      offTime_r   <= OFFT_RST;
      blankTime_r <= BLANK_RST;
    end else if (regWrEn) begin
      case (regAddr)
        OFS_DEAD:  deadTime_r  <= regWrData[7:0];
        OFS_OFFT:  offTime_r   <= regWrData[15:0];
        OFS_BLANK: blankTime_r <= regWrData[15:0];
        default:   ;
      endcase
    end
  end

  // ==========================================================
  // Chop state machine
  bgd_chop_type     chopSt_r;
  logic [TMR_W-1:0] chopCnt_r;
  logic [TMR_W-1:0] offLoad;
  logic             decayNow;
  logic [2:0]       srcOut_r;
  logic [2:0]       snkOut_r;

  assign offLoad  = (offTime_r > MIN_OFF) ? offTime_r : MIN_OFF;
  assign decayNow = (chopSt_r == CH_OFF);

  // Fixed off-time chopping with blanking of the sense comparator.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chopSt_r  <= CH_OFF;
      chopCnt_r <= MIN_OFF;
    end else if (dis) begin
      chopSt_r  <= CH_OFF;
      chopCnt_r <= MIN_OFF;
    end else begin
      case (chopSt_r)
        CH_ON: begin
          if (!chop) begin
            chopSt_r  <= CH_OFF;
            chopCnt_r <= MIN_OFF;
          end else if (syncB_r[SY_TRIP]) begin
            chopSt_r  <= CH_OFF;
            chopCnt_r <= offLoad;
          end
        end
        CH_OFF: begin
          if (chopCnt_r != '0) begin
            chopCnt_r <= chopCnt_r - 1'b1;
          end else if (chop) begin
            chopSt_r  <= CH_BLANK;
            chopCnt_r <= blankTime_r;
          end
        end
        CH_BLANK: begin
          // trip ignored here
          // Blank time runs only once a source is back on, so dead time cannot use it up.
          if (!chop) begin
            chopSt_r  <= CH_OFF;
            chopCnt_r <= MIN_OFF;
          end else if (chopCnt_r == '0) begin
            chopSt_r <= CH_ON;
          end else if (|srcOut_r) begin
            chopCnt_r <= chopCnt_r - 1'b1;
          end
        end
        default: begin
          chopSt_r  <= CH_OFF;
          chopCnt_r <= MIN_OFF;
        end
      endcase
    end
  end

  // ==========================================================
  // Fault logic
  logic       hallFault_r;
  logic       gsFault_r;
  logic       bootFault_r;
  logic       supplySeen_r;
  logic [1:0] gsCnt_r;
  logic [2:0] chargeReq_r;
  logic [2:0] gsEvent;
  logic [2:0] bootExp;
  logic       faultCoast;

  assign faultCoast = hallFault_r || gsFault_r || bootFault_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      supplySeen_r <= 1'b0;
    end else if (!uv) begin
      supplySeen_r <= 1'b1;
    end
  end

  // Latched faults; set wins over the commutation clear.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hallFault_r <= 1'b0;
      gsFault_r   <= 1'b0;
      bootFault_r <= 1'b0;
      gsCnt_r     <= '0;
    end else if (dis) begin
      hallFault_r <= 1'b0;
      gsFault_r   <= 1'b0;
      bootFault_r <= 1'b0;
      gsCnt_r     <= '0;
    end else begin
      if (hallBad) begin
        hallFault_r <= 1'b1;
      end else if (commStart) begin
        hallFault_r <= 1'b0;
      end
      if (|gsEvent) begin
        if (gsCnt_r == 2'(GS_TOLERATED)) begin
          gsFault_r <= 1'b1;
        end else begin
          gsCnt_r <= gsCnt_r + 1'b1;
        end
      end else if (commStart) begin
        gsCnt_r   <= '0;
        gsFault_r <= 1'b0;
      end
      if (|bootExp) begin
        bootFault_r <= 1'b1;
      end else if (commStart) begin
        bootFault_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Per-phase demand, recharge, bootstrap timer and dead time
  for (genvar g = 0; g < 3; g++) begin : gPhase
    bgd_drive_type    drv;
    logic             srcReq;
    logic             snkReq;
    logic             srcOff;
    logic             snkOff;
    logic [7:0]       dtCnt_r;
    logic [TMR_W-1:0] bootTmr_r;

    assign drv        = bgd_drive_type'(pat[2*g +: 2]);
    assign gsEvent[g] = srcOut_r[g] && gsLow[g] && !chargeReq_r[g];
    assign bootExp[g] = snkOut_r[g] && !bootOk[g] && (bootTmr_r == BOOT_LAST);
    assign srcOff     = srcOut_r[g] && !srcReq;
    assign snkOff     = snkOut_r[g] && !snkReq;

    // Gate demand in priority order.
    always_comb begin
      srcReq = 1'b0;
      snkReq = 1'b0;
      if (dis || !supplySeen_r) begin
        srcReq = 1'b0;
      end else if (uv) begin
        snkReq = syncB_r[SY_PLB];
      end else if (faultCoast || hallBad) begin
        srcReq = 1'b0;
      end else if (syncB_r[SY_BRK]) begin
        snkReq = 1'b1;
      end else if (drv == DRV_HI) begin
        if (chargeReq_r[g] || decayNow) begin
          snkReq = 1'b1;
        end else begin
          srcReq = 1'b1;
        end
      end else if (drv == DRV_LO) begin
        // slow keeps sink / fast drops it
        snkReq = syncB_r[SY_DEC] || !decayNow;
      end
    end

    // recharge after droop / first charge
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        chargeReq_r[g] <= 1'b1;
      end else if (dis || !supplySeen_r || gsEvent[g]
                   || (drv == DRV_HI && patPrev_r[2*g +: 2] == DRV_Z)) begin
        chargeReq_r[g] <= 1'b1;
      end else if (snkOut_r[g] && bootOk[g]) begin
        chargeReq_r[g] <= 1'b0;
      end
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        bootTmr_r <= '0;
      end else if (!snkOut_r[g] || bootOk[g]) begin
        bootTmr_r <= '0;
      end else if (bootTmr_r != BOOT_LAST) begin
        bootTmr_r <= bootTmr_r + 1'b1;
      end
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        srcOut_r[g] <= 1'b0;
        snkOut_r[g] <= 1'b0;
        dtCnt_r     <= '0;
      end else begin
        if (srcOff || snkOff) begin
          dtCnt_r <= deadTime_r;
        end else if (dtCnt_r != '0) begin
          dtCnt_r <= dtCnt_r - 1'b1;
        end
        if (srcOff) begin
          srcOut_r[g] <= 1'b0;
        end else if (srcReq && !snkOut_r[g] && dtCnt_r == '0) begin
          srcOut_r[g] <= 1'b1;
        end
        if (snkOff) begin
          snkOut_r[g] <= 1'b0;
        end else if (snkReq && !srcOut_r[g] && dtCnt_r == '0) begin
          snkOut_r[g] <= 1'b1;
        end
      end
    end
  end

  assign sourceGateOutputs = srcOut_r;
  assign sinkGateOutputs   = snkOut_r;

  // ==========================================================
  // Fault output and register read
  logic [11:0] statusWord;
  assign statusWord = {chopSt_r, chargeReq_r, gsCnt_r, supplySeen_r,
                       bootFault_r, gsFault_r, hallFault_r, uv};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      faultOut <= 1'b0;
    end else begin
      faultOut <= !dis && (faultCoast || hallBad || uv);
    end
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRdEn) begin
      case (regAddr)
        OFS_DEAD:   regRdData <= {24'h00_0000, deadTime_r};
        OFS_OFFT:   regRdData <= {16'h0000, offTime_r};
        OFS_BLANK:  regRdData <= {16'h0000, blankTime_r};
        OFS_STATUS: regRdData <= {20'h0_0000, statusWord};
        default:    regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

endmodule

// ### rtl/bgd_pkg.sv
// Purpose: Shared constants for the gate drive control block.
// Assumes: 100 MHz mclk; 32-bit register port with byte offsets.
// Notes:   Times are kept in their own unit and converted to cycles here.
package bgd_pkg;

  // ==========================================================
  // Register port
  localparam int         DATA_W     = 32;
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] OFS_DEAD   = 4'h0;
  localparam logic [3:0] OFS_OFFT   = 4'h4;
  localparam logic [3:0] OFS_BLANK  = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // ==========================================================
  // Reset values of the timing registers, in cycles
  localparam logic [7:0]  DEAD_RST  = 8'h15;
  localparam logic [15:0] OFFT_RST  = 16'h03E8;
  localparam logic [15:0] BLANK_RST = 16'h0064;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ          = 100;
  localparam int BOOT_TIMEOUT_US  = 60;
  localparam int BOOT_TIMEOUT_CYC = BOOT_TIMEOUT_US * CLK_MHZ;
  localparam int MIN_OFF_NS       = 500;
  localparam int MIN_OFF_CYC      = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W            = 16;
  localparam int GS_TOLERATED     = 3;

  // ==========================================================
  // Hall codes and drive patterns
  localparam logic [2:0] HALL_ALL_LO = 3'h0;
  localparam logic [2:0] HALL_ALL_HI = 3'h7;
  typedef enum logic [1:0] {
    DRV_Z  = 2'h0,
    DRV_LO = 2'h1,
    DRV_HI = 2'h3
  } bgd_drive_type;

  // Chop states, Gray coded along on, off, blank.
  typedef enum logic [1:0] {
    CH_ON    = 2'h0,
    CH_OFF   = 2'h1,
    CH_BLANK = 2'h3
  } bgd_chop_type;

  // ==========================================================
  // Bit positions in the synchronised input vector
  localparam int SY_HALL = 0;
  localparam int SY_DIR  = 3;
  localparam int SY_BRK  = 4;
  localparam int SY_DEC  = 5;
  localparam int SY_CHOP = 6;
  localparam int SY_DIS  = 7;
  localparam int SY_PLB  = 8;
  localparam int SY_TRIP = 9;
  localparam int SY_GS   = 10;
  localparam int SY_BOK  = 13;
  localparam int SY_SUP  = 16;
  localparam int SYNC_W  = 17;

endpackage

// ### verif/bgd_gate_ctrl_assertions.sv
// Purpose: Concurrent checks on the ports of the gate drive control block.
// Assumes: The dead time register never holds less than four cycles.
// Notes:   Bound to every instance of the control block.
`timescale 1ns/10ps
module bgd_gate_ctrl_checker #(
  parameter int BootTimeoutCyc = 6000
) (
  // Clock and reset
  input wire logic                       mclk,
  input wire logic                       rst,
  // Watched inputs
  input wire logic [2:0]                 hallInputs,
  input wire logic                       brakeIn,
  input wire logic                       disableIn,
  input wire logic                       powerLossBrakeSelect,
  input wire logic                       gateSupplyOk,
  input wire logic                       regRdEn,
  // Watched outputs
  input wire logic [2:0]                 sourceGateOutputs,
  input wire logic [2:0]                 sinkGateOutputs,
  input wire logic                       faultOut,
  input wire logic [bgd_pkg::DATA_W-1:0] regRdData
);
  logic       hallBad;
  logic [4:0] brkCnt_r;

  // A Hall code of all zeros or all ones is illegal.
  assign hallBad = (hallInputs == 3'h0) || (hallInputs == 3'h7);

  // Counts cycles of an unbroken brake request in normal running.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      brkCnt_r <= 5'h00;
    end else if (brakeIn && !disableIn && gateSupplyOk && !faultOut && !hallBad) begin
      brkCnt_r <= (brkCnt_r == 5'h1F) ? brkCnt_r : brkCnt_r + 5'h01;
    end else begin
      brkCnt_r <= 5'h00;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Gate drive, fault and read checks
  a_no_shoot_through: assert property ((sourceGateOutputs & sinkGateOutputs) == 3'h0)
    else $error("source and sink of one phase on together");
  a_dead_before_src: assert property ($fell(sinkGateOutputs[0]) |-> !sourceGateOutputs[0] [*4])
    else $error("source turned on too soon after sink");
  a_dead_before_sink: assert property ($fell(sourceGateOutputs[0]) |-> !sinkGateOutputs[0] [*4])
    else $error("sink turned on too soon after source");
  a_disable_coast: assert property (disableIn [*5] |-> !faultOut
    && sourceGateOutputs == 3'h0 && sinkGateOutputs == 3'h0)
    else $error("disable did not coast and clear");
  a_hall_fault: assert property ((hallBad && !disableIn && gateSupplyOk) [*5]
    |-> faultOut && sourceGateOutputs == 3'h0 && sinkGateOutputs == 3'h0)
    else $error("illegal hall code not handled");
  a_uv_fault: assert property ((!gateSupplyOk && !disableIn) [*5] |-> faultOut
    && sourceGateOutputs == 3'h0)
    else $error("undervoltage left a source on");
  a_uv_coast: assert property ((!gateSupplyOk && !powerLossBrakeSelect
    && !disableIn) [*5] |-> sinkGateOutputs == 3'h0)
    else $error("undervoltage without loss brake did not coast");
  a_brake_sinks: assert property (brkCnt_r >= 5'h1E |-> sinkGateOutputs == 3'h7
    && sourceGateOutputs == 3'h0)
    else $error("brake did not turn all sinks on");
  a_read_idle: assert property (!$past(regRdEn) |-> regRdData == '0)
    else $error("read data outside its read cycle");

  // ==========================================================
  // Main scenarios
  c_brake: cover property (brkCnt_r == 5'h1E);
  c_fault: cover property ($rose(faultOut));
  c_chop: cover property ($fell(sourceGateOutputs[0]));
endmodule

bind bgd_gate_ctrl bgd_gate_ctrl_checker #(.BootTimeoutCyc(BootTimeoutCyc)) u_chk (
  .mclk(mclk), .rst(rst), .hallInputs(hallInputs), .brakeIn(brakeIn),
  .disableIn(disableIn), .powerLossBrakeSelect(powerLossBrakeSelect),
  .gateSupplyOk(gateSupplyOk), .regRdEn(regRdEn), .sourceGateOutputs(sourceGateOutputs),
  .sinkGateOutputs(sinkGateOutputs), .faultOut(faultOut), .regRdData(regRdData));

// ### verif/bgd_bridge_model.sv
// Purpose: Behavioural power bridge answering the gate drive outputs.
// Assumes: A bootstrap charges a set number of cycles after its sink turns on.
// Notes:   Current ramps while any source is on; droop is commanded by the bench.
`timescale 1ns/10ps
module bgd_bridge_model (
  // Clock
  input wire logic       mclk,
  // Gate drives
  input wire logic [2:0] srcOn,
  input wire logic [2:0] sinkOn,
  // Bench knobs
  input wire logic [7:0] chargeDelay,
  input wire logic       noCharge,
  input wire logic [7:0] tripAfter,
  input wire logic       droopReq,
  // Monitor results
  output logic [2:0]     bootCharged,
  output logic [2:0]     gateSrcLow,
  output logic           senseTrip
);
  logic [7:0] chg_r [3] = '{8'h00, 8'h00, 8'h00};
  logic [2:0] full_r = 3'h0;
  logic [7:0] ramp_r = 8'h00;

  // Bootstrap charges only through its own sink and never when starved.
  always @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      if (noCharge) begin
        chg_r[i]  <= 8'h00;
        full_r[i] <= 1'b0;
      end else if (sinkOn[i]) begin
        if (chg_r[i] >= chargeDelay) full_r[i] <= 1'b1;
        else chg_r[i] <= chg_r[i] + 8'h01;
      end else begin
        chg_r[i] <= 8'h00;
      end
    end
    ramp_r <= (|srcOn) ? ((ramp_r == 8'hFF) ? ramp_r : ramp_r + 8'h01) : 8'h00;
  end

  // Monitor outputs seen by the control block.
  assign bootCharged = full_r;
  assign gateSrcLow  = {3{droopReq}} & srcOn;
  assign senseTrip   = (tripAfter != 8'h00) && (ramp_r >= tripAfter);
endmodule

// ### verif/tb.sv
// Purpose: Self-checking bench for the gate drive control block.
// Assumes: Bridge model answers charge, droop and current sense.
// Notes:   Bootstrap timeout is shortened to 50 cycles.
`timescale 1ns/10ps
module tb;
  import bgd_pkg::*;
  // ==========================================================
  // Signals
  logic        mclk, rst, dirIn, brakeIn, decaySel, speedChop, disableIn, plbSel;
  logic        noCharge, droopReq, gateSupplyOk, senseTrip, faultOut;
  logic        regWrEn, regRdEn, rdFlag = 1'b0;
  logic [2:0]  hallInputs, gateSrcLow, bootCharged, srcG, sinkG;
  logic [3:0]  regAddr;
  logic [7:0]  chargeDelay, tripAfter;
  logic [31:0] regWrData, regRdData, offt, dead;
  logic [31:0] rdQ[$];
  int          n_fail = 0, comparisons = 0, n;
  logic [2:0]  hc [6] = '{3'b101, 3'b100, 3'b110, 3'b010, 3'b011, 3'b001};
  logic [2:0]  sm [6] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1};
  logic [2:0]  km [6] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2};

  bgd_gate_ctrl #(.BootTimeoutCyc(50)) u_dut (.mclk(mclk), .rst(rst),
    .hallInputs(hallInputs), .dirIn(dirIn), .brakeIn(brakeIn), .decaySel(decaySel),
    .speedChop(speedChop), .disableIn(disableIn), .powerLossBrakeSelect(plbSel),
    .senseTrip(senseTrip), .gateSrcLow(gateSrcLow), .bootCharged(bootCharged),
    .gateSupplyOk(gateSupplyOk), .sourceGateOutputs(srcG), .sinkGateOutputs(sinkG),
    .faultOut(faultOut), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData));
  bgd_bridge_model u_br (.mclk(mclk), .srcOn(srcG), .sinkOn(sinkG),
    .chargeDelay(chargeDelay), .noCharge(noCharge), .tripAfter(tripAfter),
    .droopReq(droopReq), .bootCharged(bootCharged), .gateSrcLow(gateSrcLow),
    .senseTrip(senseTrip));

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= w;
    regRdEn   <= !w;
    if (!w) rdQ.push_back(d);
    @(posedge mclk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
  endtask
  task automatic waitG(input logic [2:0] s, input logic [2:0] k);
    for (int i = 0; i < 600 && !(srcG === s && sinkG === k); i++) @(negedge mclk);
    check(srcG, s);
    check(sinkG, k);
  endtask
  task automatic waitF(input logic v);
    for (int i = 0; i < 600 && faultOut !== v; i++) @(negedge mclk);
    check(faultOut, v);
  endtask
  task automatic cnt(input logic v);
    n = 0;
    while ((|srcG) === v && n < 3000) begin
      @(negedge mclk);
      n++;
    end
  endtask

  // Clock of 10 ns period.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Read data stand in the cycle after the strobe; compare with the oldest note.
  always @(posedge mclk) rdFlag <= regRdEn;
  always @(negedge mclk) if (rdFlag) check(regRdData, rdQ.pop_front());

  // Cuts a hang short.
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {rst, dirIn, brakeIn, decaySel, speedChop, disableIn, plbSel} = 7'b1101100;
    {noCharge, droopReq, gateSupplyOk, regWrEn, regRdEn} = 5'h00;
    hallInputs = 3'h5;
    regAddr = 4'h0;
    regWrData = '0;
    tripAfter = 8'h00;
    void'($urandom(45861));
    chargeDelay = 8'(3 + $urandom % 8);
    dead = 32'(4 + $urandom % 9);
    offt = 32'(60 + $urandom % 61);
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    bus(0, OFS_DEAD, 32'(DEAD_RST));
    bus(0, OFS_OFFT, 32'(OFFT_RST));
    bus(0, OFS_BLANK, 32'(BLANK_RST));
    bus(1, OFS_DEAD, dead);
    bus(1, OFS_OFFT, offt);
    bus(1, OFS_BLANK, 32'h0000_0014);
    bus(1, 4'h6, 32'h0000_1234);
    bus(0, OFS_DEAD, dead);
    bus(0, OFS_OFFT, offt);
    bus(0, 4'h6, 32'h0000_0000);
    @(negedge mclk);
    check(srcG | sinkG, 0);
    check(faultOut, 1);
    $display("test registers and power-up done");
    @(posedge mclk) gateSupplyOk <= 1'b1;
    for (int d = 1; d >= 0; d--) begin
      for (int i = 0; i < 6; i++) begin
        @(posedge mclk);
        dirIn      <= d[0];
        hallInputs <= hc[i];
        waitG(d ? sm[i] : km[i], d ? km[i] : sm[i]);
      end
    end
    $display("test commutation done");
    @(posedge mclk) {dirIn, hallInputs} <= 4'hD;
    waitG(3'h1, 3'h4);
    @(posedge mclk) speedChop <= 1'b0;
    waitG(3'h0, 3'h5);
    @(posedge mclk) decaySel <= 1'b0;
    waitG(3'h0, 3'h1);
    @(posedge mclk) speedChop <= 1'b1;
    waitG(3'h1, 3'h4);
    @(posedge mclk) speedChop <= 1'b0;
    @(posedge mclk) speedChop <= 1'b1;
    waitG(3'h0, 3'h1);
    cnt(0);
    check(32'(n >= MIN_OFF_CYC), 1);
    waitG(3'h1, 3'h4);
    @(posedge mclk) tripAfter <= 8'h01;
    waitG(3'h0, 3'h1);
    cnt(0);
    check(32'(n >= offt), 1);
    cnt(1);
    check(32'(n >= 20), 1);
    @(posedge mclk) tripAfter <= 8'h00;
    waitG(3'h1, 3'h4);
    $display("test chopping done");
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk) droopReq <= 1'b1;
      waitG(3'h0, 3'h5);
      @(posedge mclk) droopReq <= 1'b0;
      waitG(3'h1, 3'h4);
    end
    check(faultOut, 0);
    @(posedge mclk) droopReq <= 1'b1;
    waitF(1);
    waitG(3'h0, 3'h0);
    @(posedge mclk) droopReq <= 1'b0;
    @(posedge mclk) hallInputs <= 3'h1;
    waitF(0);
    $display("test droop done");
    foreach (hc[i]) if (i < 2) begin
      @(posedge mclk) hallInputs <= i ? 3'h7 : 3'h0;
      waitF(1);
      waitG(3'h0, 3'h0);
      @(posedge mclk) hallInputs <= 3'h5;
      waitF(0);
    end
    @(posedge mclk) noCharge <= 1'b1;
    waitF(1);
    waitG(3'h0, 3'h0);
    @(posedge mclk) noCharge <= 1'b0;
    repeat (100) @(negedge mclk);
    check(faultOut, 1);
    @(posedge mclk) disableIn <= 1'b1;
    repeat (4) @(posedge mclk);
    disableIn <= 1'b0;
    waitF(0);
    waitG(3'h1, 3'h4);
    $display("test faults done");
    @(posedge mclk) brakeIn <= 1'b1;
    waitG(3'h0, 3'h7);
    @(posedge mclk) disableIn <= 1'b1;
    waitG(3'h0, 3'h0);
    check(faultOut, 0);
    @(posedge mclk) {disableIn, brakeIn, plbSel, gateSupplyOk} <= 4'h2;
    waitG(3'h0, 3'h7);
    waitF(1);
    @(posedge mclk) {brakeIn, plbSel} <= 2'b10;
    waitG(3'h0, 3'h0);
    $display("test brake and undervoltage done");
    results();
  end
endmodule
